// [verilog/irq_pkg.sv]
package irq_pkg;

  // Source count and priority width
  localparam int          NUM_SRC      = 7;
  localparam int          LVL_W        = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_TIMER     = 8'h88;
  localparam logic [7:0] ADDR_SERIAL    = 8'h98;
  localparam logic [7:0] ADDR_ENABLE    = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_A    = 8'hA9;
  localparam logic [7:0] ADDR_PRIO_B    = 8'hAA;
  localparam logic [7:0] ADDR_CONTROL   = 8'hAB;
  localparam logic [7:0] ADDR_ACQ_SYNC  = 8'hC0;
  localparam logic [7:0] ADDR_DISP_SYNC = 8'hC8;
  localparam logic [7:0] ADDR_CONVERTER = 8'hD8;

  // Reset values
  localparam logic [7:0] RST_REG        = 8'h00;

  // Field positions
  localparam int BIT_EXT_A_EDGE   = 0;
  localparam int BIT_EXT_A_FLAG   = 1;
  localparam int BIT_EXT_B_EDGE   = 2;
  localparam int BIT_EXT_B_FLAG   = 3;
  localparam int BIT_CNT_A_OVF    = 5;
  localparam int BIT_CNT_B_OVF    = 7;
  localparam int BIT_SER_RX       = 0;
  localparam int BIT_SER_TX       = 1;
  localparam int BIT_GLOBAL_EN    = 7;
  localparam int BIT_CONV_DONE    = 5;
  localparam int BIT_DHS_FLAG     = 0;
  localparam int BIT_DHS_EN       = 1;
  localparam int BIT_DVS_FLAG     = 2;
  localparam int BIT_DVS_EN       = 3;
  localparam int BIT_AHS_FLAG     = 0;
  localparam int BIT_AVS_FLAG     = 2;
  localparam int BIT_LINE_FLAG    = 4;
  localparam int BIT_EVEN_FLAG    = 6;
  localparam logic [7:0] DISP_SYNC_MASK = 8'h7F;

  // Source indices, in ascending vector order
  localparam int SRC_EXT_A  = 0;
  localparam int SRC_CNT_A  = 1;
  localparam int SRC_EXT_B  = 2;
  localparam int SRC_CNT_B  = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_SYNC   = 5;
  localparam int SRC_CONV   = 6;

  // Vector of source i is VEC_BASE + i * VEC_STEP
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;

  // Positions inside the asynchronous input vector
  localparam int AIN_DVS  = 0;
  localparam int AIN_DHS  = 1;
  localparam int AIN_AVS  = 2;
  localparam int AIN_AHS  = 3;
  localparam int AIN_EVEN = 4;
  localparam int AIN_LINE = 5;
  localparam int AIN_EXTA = 6;
  localparam int AIN_EXTB = 7;
  localparam int AIN_W    = 8;

  // Response window and its cycle counts at the system clock
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int RESP_MIN_PS    = 890000;
  localparam int RESP_MAX_PS    = 2330000;
  localparam int RESP_MIN_CYC   = (RESP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESP_MAX_CYC   = RESP_MAX_PS / CLK_PERIOD_PS;

  // Register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_type;

  // Request presented to the core
  typedef struct packed {
    logic             req;
    logic [LVL_W-1:0] level;
    logic [7:0]       vector;
  } cpu_irq_type;

endpackage

// [verilog/irq_system.sv]
// Notes on behaviour
// - Seven request sources are collected
// - Four levels, per-source enable, global enable
// - Higher level preempts lower level service
// - Fixed vector per source, 03h step 08h
// - Flags sit at fixed timer register bits
// - Counter overflow sets flag, not counter A mode 3
// - Serial request on receive or transmit done
// - Sync request when any enabled flag set
// - Six sync events from display and acquisition
// - Sync events resynchronised from their clock system
// - Conversion done sets converter flag
// - Enable register: seven enables plus global
// - Software writes act like hardware on flags
// - Registers sit at their fixed addresses
// - Request reaches core within response window
// - Display vsync rising edge sets sticky flag
// - Each sync event has its own enable
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irq_system
(
  input  wire                  CLK_SYS,
  input  wire                  RST_N,
  input  wire irq_pkg::sfr_req_type SFR_REQ,
  output logic [7:0]           SFR_RDATA,
  input  wire logic [7:0]      ASYNC_IN,
  input  wire logic            CNT_A_OVF,
  input  wire logic            CNT_A_MODE3,
  input  wire logic            CNT_B_OVF,
  input  wire logic            SER_RX_DONE,
  input  wire logic            SER_TX_DONE,
  input  wire logic            CONV_DONE,
  input  wire logic            IRQ_ACK,
  input  wire logic            IRQ_RETI,
  output irq_pkg::cpu_irq_type IRQ_OUT,
  output logic [3:0]           IN_SERVICE
);
  import irq_pkg::*;

  // Synchroniser reset level: both request pins idle high, so reset shows no false low or edge
  localparam logic [AIN_W-1:0] AIN_IDLE = AIN_W'((1 << AIN_EXTA) | (1 << AIN_EXTB));

  // Register file
  logic [7:0] timer_ctrl_flags_r, timer_ctrl_flags_nxt;
  logic [7:0] serial_ctrl_flags_r, serial_ctrl_flags_nxt;
  logic [7:0] irq_enable_reg_r, irq_enable_reg_nxt;
  logic [7:0] priority_reg_a_r, priority_reg_a_nxt;
  logic [7:0] priority_reg_b_r, priority_reg_b_nxt;
  logic [7:0] irq_control_reg_r, irq_control_reg_nxt;
  logic [7:0] acq_sync_irq_reg_r, acq_sync_irq_reg_nxt;
  logic [7:0] display_sync_irq_reg_r, display_sync_irq_reg_nxt;
  logic [7:0] converter_ctrl_reg_r, converter_ctrl_reg_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Input synchronisers: stage one feeds stage two only
  logic [AIN_W-1:0] meta_r;
  logic [AIN_W-1:0] sync_r;
  logic [AIN_W-1:0] prev_r;

  // Nesting state and presented request
  logic [3:0]  in_service_r, in_service_nxt;
  cpu_irq_type irq_r, irq_nxt;

  // Combinational decode
  logic [NUM_SRC-1:0] raw_req;       // Flag view per source
  logic [NUM_SRC-1:0] en_req;        // After individual and global enables
  logic               sync_any;      // Combined sync source
  logic [AIN_W-1:0]   rise;          // Rising edges of synced inputs
  logic [AIN_W-1:0]   fall;          // Falling edges of synced inputs
  logic               win_valid;     // A request may preempt
  logic [LVL_W-1:0]   win_level;     // Level of chosen source
  logic [2:0]         win_idx;       // Chosen source
  logic [LVL_W-1:0]   top_level;     // Highest level in service
  logic               any_service;   // Some level in service
  logic               wr_hit;        // Helper for write decode

  // Two flops before any logic reads the outside inputs
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      meta_r <= AIN_IDLE;
      sync_r <= AIN_IDLE;
      prev_r <= AIN_IDLE;
    end
    else
    begin
      meta_r <= ASYNC_IN;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
  assign wr_hit = SFR_REQ.wr;

  // Flag and control registers; hardware sets win over software clears
  always_comb
  begin
    timer_ctrl_flags_nxt      = timer_ctrl_flags_r;
    serial_ctrl_flags_nxt     = serial_ctrl_flags_r;
    irq_enable_reg_nxt        = irq_enable_reg_r;
    priority_reg_a_nxt        = priority_reg_a_r;
    priority_reg_b_nxt        = priority_reg_b_r;
    irq_control_reg_nxt       = irq_control_reg_r;
    acq_sync_irq_reg_nxt      = acq_sync_irq_reg_r;
    display_sync_irq_reg_nxt  = display_sync_irq_reg_r;
    converter_ctrl_reg_nxt    = converter_ctrl_reg_r;
    // Vectoring clears edge-mode external and overflow flags, as the core expects
    if (IRQ_ACK && irq_r.req)
    begin
      case (irq_r.vector)
        VEC_BASE:
          if (timer_ctrl_flags_r[BIT_EXT_A_EDGE])
            timer_ctrl_flags_nxt[BIT_EXT_A_FLAG] = 1'b0;
        VEC_BASE + VEC_STEP:
          timer_ctrl_flags_nxt[BIT_CNT_A_OVF] = 1'b0;
        VEC_BASE + 8'h10:
          if (timer_ctrl_flags_r[BIT_EXT_B_EDGE])
            timer_ctrl_flags_nxt[BIT_EXT_B_FLAG] = 1'b0;
        VEC_BASE + 8'h18:
          timer_ctrl_flags_nxt[BIT_CNT_B_OVF] = 1'b0;
        default:
          timer_ctrl_flags_nxt = timer_ctrl_flags_nxt;
      endcase
    end
    // Software write: same effect as hardware on every flag
    if (wr_hit)
    begin
      case (SFR_REQ.addr)
        ADDR_TIMER:     timer_ctrl_flags_nxt     = SFR_REQ.wdata;
        ADDR_SERIAL:    serial_ctrl_flags_nxt    = SFR_REQ.wdata;
        ADDR_ENABLE:    irq_enable_reg_nxt       = SFR_REQ.wdata;
        ADDR_PRIO_A:    priority_reg_a_nxt       = SFR_REQ.wdata;
        ADDR_PRIO_B:    priority_reg_b_nxt       = SFR_REQ.wdata;
        ADDR_CONTROL:   irq_control_reg_nxt      = SFR_REQ.wdata;
        ADDR_ACQ_SYNC:  acq_sync_irq_reg_nxt     = SFR_REQ.wdata;
        ADDR_DISP_SYNC: display_sync_irq_reg_nxt = SFR_REQ.wdata & DISP_SYNC_MASK;
        ADDR_CONVERTER: converter_ctrl_reg_nxt   = SFR_REQ.wdata;
        default:        irq_control_reg_nxt      = irq_control_reg_nxt;
      endcase
    end
    // External pins are active low: falling edge or low level by mode bit
    if (timer_ctrl_flags_r[BIT_EXT_A_EDGE] ? fall[AIN_EXTA] : !sync_r[AIN_EXTA])
      timer_ctrl_flags_nxt[BIT_EXT_A_FLAG] = 1'b1;
    if (timer_ctrl_flags_r[BIT_EXT_B_EDGE] ? fall[AIN_EXTB] : !sync_r[AIN_EXTB])
      timer_ctrl_flags_nxt[BIT_EXT_B_FLAG] = 1'b1;
    // Counter A in mode 3 no longer drives its own overflow flag
    if (CNT_A_OVF && !CNT_A_MODE3)
      timer_ctrl_flags_nxt[BIT_CNT_A_OVF] = 1'b1;
    if (CNT_B_OVF)
      timer_ctrl_flags_nxt[BIT_CNT_B_OVF] = 1'b1;
    if (SER_RX_DONE)
      serial_ctrl_flags_nxt[BIT_SER_RX] = 1'b1;
    if (SER_TX_DONE)
      serial_ctrl_flags_nxt[BIT_SER_TX] = 1'b1;
    if (CONV_DONE)
      converter_ctrl_reg_nxt[BIT_CONV_DONE] = 1'b1;
    // Sync flags are sticky; only software clears them
    if (rise[AIN_DVS])
      display_sync_irq_reg_nxt[BIT_DVS_FLAG] = 1'b1;
    if (rise[AIN_DHS])
      display_sync_irq_reg_nxt[BIT_DHS_FLAG] = 1'b1;
    if (rise[AIN_EVEN])
      acq_sync_irq_reg_nxt[BIT_EVEN_FLAG] = 1'b1;
    if (rise[AIN_LINE])
      acq_sync_irq_reg_nxt[BIT_LINE_FLAG] = 1'b1;
    if (rise[AIN_AVS])
      acq_sync_irq_reg_nxt[BIT_AVS_FLAG] = 1'b1;
    if (rise[AIN_AHS])
      acq_sync_irq_reg_nxt[BIT_AHS_FLAG] = 1'b1;
  end

  // Read data stand in the cycle after the read strobe only
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (SFR_REQ.rd)
    begin
      case (SFR_REQ.addr)
        ADDR_TIMER:     rdata_nxt = timer_ctrl_flags_r;
        ADDR_SERIAL:    rdata_nxt = serial_ctrl_flags_r;
        ADDR_ENABLE:    rdata_nxt = irq_enable_reg_r;
        ADDR_PRIO_A:    rdata_nxt = priority_reg_a_r;
        ADDR_PRIO_B:    rdata_nxt = priority_reg_b_r;
        ADDR_CONTROL:   rdata_nxt = irq_control_reg_r;
        ADDR_ACQ_SYNC:  rdata_nxt = acq_sync_irq_reg_r;
        ADDR_DISP_SYNC: rdata_nxt = display_sync_irq_reg_r;
        ADDR_CONVERTER: rdata_nxt = converter_ctrl_reg_r;
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // Each sync flag counts only with its own enable beside it
  assign sync_any =
    (display_sync_irq_reg_r[BIT_DVS_FLAG] & display_sync_irq_reg_r[BIT_DVS_EN]) |
    (display_sync_irq_reg_r[BIT_DHS_FLAG] & display_sync_irq_reg_r[BIT_DHS_EN]) |
    (acq_sync_irq_reg_r[BIT_EVEN_FLAG] & acq_sync_irq_reg_r[BIT_EVEN_FLAG+1]) |
    (acq_sync_irq_reg_r[BIT_LINE_FLAG] & acq_sync_irq_reg_r[BIT_LINE_FLAG+1]) |
    (acq_sync_irq_reg_r[BIT_AVS_FLAG] & acq_sync_irq_reg_r[BIT_AVS_FLAG+1]) |
    (acq_sync_irq_reg_r[BIT_AHS_FLAG] & acq_sync_irq_reg_r[BIT_AHS_FLAG+1]);

  // Per-source request view
  always_comb
  begin
    raw_req             = '0;
    raw_req[SRC_EXT_A]  = timer_ctrl_flags_r[BIT_EXT_A_FLAG];
    raw_req[SRC_CNT_A]  = timer_ctrl_flags_r[BIT_CNT_A_OVF];
    raw_req[SRC_EXT_B]  = timer_ctrl_flags_r[BIT_EXT_B_FLAG];
    raw_req[SRC_CNT_B]  = timer_ctrl_flags_r[BIT_CNT_B_OVF];
    raw_req[SRC_SERIAL] = serial_ctrl_flags_r[BIT_SER_RX] |
                          serial_ctrl_flags_r[BIT_SER_TX];
    raw_req[SRC_SYNC]   = sync_any;
    raw_req[SRC_CONV]   = converter_ctrl_reg_r[BIT_CONV_DONE];
  end

  // Seven enables, then the global gate over all of them
  assign en_req = raw_req & irq_enable_reg_r[NUM_SRC-1:0]
                & {NUM_SRC{irq_enable_reg_r[BIT_GLOBAL_EN]}};

  // Arbiter: highest level wins, lower index wins a tie, must beat service
  always_comb
  begin
    logic             found;
    logic [LVL_W-1:0] lvl;
    found       = 1'b0;
    lvl         = '0;
    win_level   = '0;
    win_idx     = 3'h0;
    top_level   = '0;
    any_service = |in_service_r;
    for (int l = 0; l < 4; l++)
      if (in_service_r[l])
        top_level = LVL_W'(l);
    for (int i = 0; i < NUM_SRC; i++)
    begin
      lvl = {priority_reg_b_r[i], priority_reg_a_r[i]};
      if (en_req[i] && (!found || lvl > win_level))
      begin
        found     = 1'b1;
        win_level = lvl;
        win_idx   = 3'(i);
      end
    end
    win_valid = found && (!any_service || win_level > top_level);
  end

  // Presented request and nesting stack
  always_comb
  begin
    irq_nxt        = irq_r;
    in_service_nxt = in_service_r;
    // Return retires the highest level in service
    if (IRQ_RETI && any_service)
      in_service_nxt[top_level] = 1'b0;
    // Taken vector marks its level busy until its return
    if (IRQ_ACK && irq_r.req)
      in_service_nxt[irq_r.level] = 1'b1;
    // Withdrawn while the core vectors so a stale request is not taken twice
    irq_nxt.req    = win_valid && !IRQ_ACK && !IRQ_RETI;
    irq_nxt.level  = win_level;
    irq_nxt.vector = VEC_BASE + 8'({win_idx, 3'b000});
  end

  // Registers
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      timer_ctrl_flags_r     <= RST_REG;
      serial_ctrl_flags_r    <= RST_REG;
      irq_enable_reg_r       <= RST_REG;
      priority_reg_a_r       <= RST_REG;
      priority_reg_b_r       <= RST_REG;
      irq_control_reg_r      <= RST_REG;
      acq_sync_irq_reg_r     <= RST_REG;
      display_sync_irq_reg_r <= RST_REG;
      converter_ctrl_reg_r   <= RST_REG;
      rdata_r                <= 8'h00;
      in_service_r           <= 4'h0;
      irq_r                  <= '0;
    end
    else
    begin
      timer_ctrl_flags_r     <= timer_ctrl_flags_nxt;
      serial_ctrl_flags_r    <= serial_ctrl_flags_nxt;
      irq_enable_reg_r       <= irq_enable_reg_nxt;
      priority_reg_a_r       <= priority_reg_a_nxt;
      priority_reg_b_r       <= priority_reg_b_nxt;
      irq_control_reg_r      <= irq_control_reg_nxt;
      acq_sync_irq_reg_r     <= acq_sync_irq_reg_nxt;
      display_sync_irq_reg_r <= display_sync_irq_reg_nxt;
      converter_ctrl_reg_r   <= converter_ctrl_reg_nxt;
      rdata_r                <= rdata_nxt;
      in_service_r           <= in_service_nxt;
      irq_r                  <= irq_nxt;
    end
  end

  assign SFR_RDATA  = rdata_r;
  assign IRQ_OUT    = irq_r;
  assign IN_SERVICE = in_service_r;

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence dvs_edge_s;
    sync_r[AIN_DVS] && !prev_r[AIN_DVS];
  endsequence

  sequence idle_core_s;
    !IRQ_ACK && !IRQ_RETI;
  endsequence

  vector_fixed_a: assert property (irq_r.req |-> irq_r.vector[2:0] == 3'h3
    && irq_r.vector <= 8'h33) else $error("Vector outside fixed table");
  global_gate_a: assert property ((!irq_enable_reg_r[BIT_GLOBAL_EN] and idle_core_s)
    |=> !irq_r.req) else $error("Request with global enable off");
  nest_rank_a: assert property (irq_r.req && (|in_service_r) |-> irq_r.level
    > $past(top_level)) else $error("Request does not outrank service");
  resp_time_a: assert property (win_valid ##0 idle_core_s |=> irq_r.req)
    else $error("Request not presented in one cycle");
  dvs_sticky_a: assert property (dvs_edge_s ##1 (!wr_hit [*2])
    |-> display_sync_irq_reg_r[BIT_DVS_FLAG]) else $error("Vsync flag lost");
  mode3_quiet_a: assert property (CNT_A_OVF && CNT_A_MODE3 && !wr_hit
    && !timer_ctrl_flags_r[BIT_CNT_A_OVF] |=> !timer_ctrl_flags_r[BIT_CNT_A_OVF])
    else $error("Mode 3 overflow set flag");
  conv_set_a: assert property (CONV_DONE |=> converter_ctrl_reg_r[BIT_CONV_DONE])
    else $error("Conversion flag not set");
  sw_set_a: assert property (wr_hit && SFR_REQ.addr == ADDR_SERIAL
    && SFR_REQ.wdata[BIT_SER_TX] |=> serial_ctrl_flags_r[BIT_SER_TX])
    else $error("Software set of serial flag lost");
  enable_read_a: assert property (SFR_REQ.rd && SFR_REQ.addr == ADDR_ENABLE
    && !$past(wr_hit) |=> SFR_RDATA == $past(irq_enable_reg_r))
    else $error("Enable register read wrong");

endmodule
`default_nettype wire

// [sim/cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import irq_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire cpu_irq_type  irq,
  input  wire logic [3:0]   ack_delay,
  input  wire logic         reti_req,
  output logic              ack,
  output logic              reti,
  output logic [7:0]        taken_vec,
  output logic [1:0]        taken_lvl,
  output logic [7:0]        ack_cnt
);
  logic [3:0] wait_cnt;  // Cycles the request has waited so far

  // Core side: takes a standing request after ack_delay cycles, one cycle pulse.
  // A slow core lets later requests overtake the first one before the take.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack       <= 1'b0;
      reti      <= 1'b0;
      wait_cnt  <= 4'h0;
      taken_vec <= 8'h00;
      taken_lvl <= 2'h0;
      ack_cnt   <= 8'h00;
    end
    else
    begin
      reti <= reti_req;
      if (ack)
        ack <= 1'b0;  // Never two takes in a row
      else if (irq.req && wait_cnt == ack_delay)
      begin
        ack      <= 1'b1;
        wait_cnt <= 4'h0;
      end
      else if (irq.req)
        wait_cnt <= wait_cnt + 4'h1;
      else
        wait_cnt <= 4'h0;  // Withdrawn request restarts the wait
      // Jump target and level as seen at the take edge
      if (ack)
      begin
        taken_vec <= irq.vector;
        taken_lvl <= irq.level;
        ack_cnt   <= ack_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  sfr_req_type sfr_req = '0;
  logic [7:0]  sfr_rdata;
  logic [7:0]  async_in = 8'hC0;  // External pins idle high
  logic [6:0]  hw = 7'h00;        // ovf a, mode3, ovf b, rx, tx, conv
  logic        irq_ack;
  logic        irq_reti;
  cpu_irq_type irq_out;
  logic [3:0]  in_service;
  logic [3:0]  ack_delay = 4'h8;
  logic        reti_req = 1'b0;
  logic [7:0]  taken_vec;
  logic [1:0]  taken_lvl;
  logic [7:0]  ack_cnt;
  int          miscompares = 0;
  int          tests_run = 0;
  // Software set of each request flag and the vector it must reach
  logic [7:0]  sa [13] = '{ADDR_TIMER, ADDR_TIMER, ADDR_TIMER, ADDR_TIMER, ADDR_SERIAL,
    ADDR_SERIAL, ADDR_DISP_SYNC, ADDR_DISP_SYNC, ADDR_ACQ_SYNC, ADDR_ACQ_SYNC,
    ADDR_ACQ_SYNC, ADDR_ACQ_SYNC, ADDR_CONVERTER};
  logic [7:0]  sv [13] = '{8'h07, 8'h25, 8'h0D, 8'h85, 8'h01, 8'h02, 8'h03, 8'h0C, 8'h03,
    8'h0C, 8'h30, 8'hC0, 8'h20};
  logic [7:0]  ve [13] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h23, 8'h2B, 8'h2B, 8'h2B,
    8'h2B, 8'h2B, 8'h2B, 8'h33};
  logic [7:0]  ra [10] = '{ADDR_TIMER, ADDR_SERIAL, ADDR_ENABLE, ADDR_PRIO_A, ADDR_PRIO_B,
    ADDR_CONTROL, ADDR_ACQ_SYNC, ADDR_DISP_SYNC, ADDR_CONVERTER, 8'h55};

  always #4 clk_sys = ~clk_sys;

  irq_system dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
    .ASYNC_IN(async_in), .CNT_A_OVF(hw[0]), .CNT_A_MODE3(hw[1]), .CNT_B_OVF(hw[2]),
    .SER_RX_DONE(hw[3]), .SER_TX_DONE(hw[4]), .CONV_DONE(hw[5]), .IRQ_ACK(irq_ack),
    .IRQ_RETI(irq_reti), .IRQ_OUT(irq_out), .IN_SERVICE(in_service));

  cpu_model cpu (.clk(clk_sys), .rst_n(rst_n), .irq(irq_out), .ack_delay(ack_delay),
    .reti_req(reti_req), .ack(irq_ack), .reti(irq_reti), .taken_vec(taken_vec),
    .taken_lvl(taken_lvl), .ack_cnt(ack_cnt));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h, wanted %h", $time, got, exp);
    end
  endtask

  // One-cycle bus strobes, launched just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= {a, d, 2'b10};
    @(posedge clk_sys);
    sfr_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_req <= {a, 8'h00, 2'b01};
    @(posedge clk_sys);
    sfr_req <= '0;
    @(negedge clk_sys);
    check(sfr_rdata, exp);
    // One cycle later the read port is back to zero
    @(negedge clk_sys);
    check(sfr_rdata, 8'h00);
  endtask

  // Peripheral done pulse on hw bit w, then let it settle
  task automatic pulse(input int w);
    @(posedge clk_sys);
    hw[w] <= 1'b1;
    @(posedge clk_sys);
    hw[w] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // Wait for the core to take a request, bounded by the response window
  task automatic serve(input logic [7:0] vec, input logic [1:0] lvl, input logic [3:0] isr);
    logic [7:0] n;
    n = ack_cnt;
    for (int k = 0; k < RESP_MAX_CYC && ack_cnt == n; k++)
      @(posedge clk_sys);
    @(negedge clk_sys);
    check(ack_cnt - n, 8'h01);
    check(taken_vec, vec);
    check({6'h00, taken_lvl}, {6'h00, lvl});
    check({4'h0, in_service}, {4'h0, isr});
  endtask

  task automatic reti;
    @(posedge clk_sys);
    reti_req <= 1'b1;
    @(posedge clk_sys);
    reti_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // No request may show for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(negedge clk_sys);
      seen = seen | irq_out.req;
    end
    check({7'h00, seen}, 8'h00);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the sequence needs
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Every register clears, an unmapped place reads zero
    foreach (ra[i]) chk_rd(ra[i], RST_REG);
    wr(ADDR_PRIO_A, 8'h5A);
    chk_rd(ADDR_PRIO_A, 8'h5A);
    wr(ADDR_PRIO_B, 8'hA5);
    chk_rd(ADDR_PRIO_B, 8'hA5);
    wr(ADDR_CONTROL, 8'h3C);
    chk_rd(ADDR_CONTROL, 8'h3C);
    wr(ADDR_DISP_SYNC, 8'hFF);
    chk_rd(ADDR_DISP_SYNC, DISP_SYNC_MASK);
    wr(ADDR_DISP_SYNC, 8'h00);
    wr(ADDR_PRIO_A, 8'h00);
    wr(ADDR_PRIO_B, 8'h00);
    // Hardware events land on their flag bits, all sources masked
    hw[1] <= 1'b1;
    pulse(0);
    chk_rd(ADDR_TIMER, 8'h00);
    hw[1] <= 1'b0;
    pulse(0);
    chk_rd(ADDR_TIMER, 8'h20);
    pulse(2);
    chk_rd(ADDR_TIMER, 8'hA0);
    wr(ADDR_TIMER, 8'h00);
    pulse(3);
    chk_rd(ADDR_SERIAL, 8'h01);
    pulse(4);
    chk_rd(ADDR_SERIAL, 8'h03);
    wr(ADDR_SERIAL, 8'h00);
    pulse(5);
    chk_rd(ADDR_CONVERTER, 8'h20);
    wr(ADDR_CONVERTER, 8'h00);
    async_in[0] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    async_in[0] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk_rd(ADDR_DISP_SYNC, 8'h04);
    wr(ADDR_DISP_SYNC, 8'h00);
    chk_rd(ADDR_DISP_SYNC, 8'h00);
    async_in[5:2] <= 4'hF;
    repeat (5) @(posedge clk_sys);
    async_in[5:2] <= 4'h0;
    chk_rd(ADDR_ACQ_SYNC, 8'h55);
    wr(ADDR_ACQ_SYNC, 8'h00);
    wr(ADDR_TIMER, 8'h01);
    async_in[6] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    async_in[6] <= 1'b1;
    chk_rd(ADDR_TIMER, 8'h03);
    // Edge modes let vectoring clear the software-set pin flags; the idle high pin sets neither flag in either mode
    wr(ADDR_TIMER, 8'h05);
    wr(ADDR_ENABLE, 8'hFF);
    // Each source set by software reaches its own vector
    foreach (sa[i])
    begin
      wr(sa[i], sv[i]);
      chk_rd(sa[i], sv[i]);
      serve(ve[i], 2'h0, 4'h1);
      wr(sa[i], (sa[i] == ADDR_TIMER) ? 8'h05 : 8'h00);
      reti();
    end
    // A flag without its own enable stays silent
    wr(ADDR_DISP_SYNC, 8'h04);
    quiet(10);
    wr(ADDR_DISP_SYNC, 8'h0C);
    serve(8'h2B, 2'h0, 4'h1);
    wr(ADDR_DISP_SYNC, 8'h00);
    reti();
    // Global enable off blocks an enabled source
    wr(ADDR_ENABLE, 8'h7F);
    wr(ADDR_CONVERTER, 8'h20);
    quiet(10);
    wr(ADDR_ENABLE, 8'hFF);
    serve(8'h33, 2'h0, 4'h1);
    wr(ADDR_CONVERTER, 8'h00);
    reti();
    // Same level tie: serial overtakes the converter before the slow take
    wr(ADDR_CONVERTER, 8'h20);
    wr(ADDR_SERIAL, 8'h01);
    serve(8'h23, 2'h0, 4'h1);
    wr(ADDR_SERIAL, 8'h00);
    reti();
    serve(8'h33, 2'h0, 4'h1);
    wr(ADDR_CONVERTER, 8'h00);
    reti();
    // Nesting with a prompt core: converter level 1, pin B level 3, serial level 0
    ack_delay <= 4'h0;
    wr(ADDR_PRIO_A, 8'h44);
    wr(ADDR_PRIO_B, 8'h04);
    wr(ADDR_CONVERTER, 8'h20);
    serve(8'h33, 2'h1, 4'h2);
    wr(ADDR_SERIAL, 8'h01);
    quiet(10);
    wr(ADDR_TIMER, 8'h0D);
    serve(8'h13, 2'h3, 4'hA);
    reti();
    check({4'h0, in_service}, 8'h02);
    wr(ADDR_CONVERTER, 8'h00);
    reti();
    serve(8'h23, 2'h0, 4'h1);
    wr(ADDR_SERIAL, 8'h00);
    reti();
    check({4'h0, in_service}, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
